// *** rtl/cfs_pkg.sv ***
// Purpose: Shared constants and types for the flags and segment addressing core
// Assumes: 16-bit data path, 20-bit physical addresses
// Notes: Reserved flag bits read back as a fixed value
`default_nettype none
package cfs_pkg;
	// ************************************************************
	// Widths
	// ************************************************************
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 20;
	localparam int unsigned SEG_SHIFT = 4;
	localparam int unsigned BYTE_MSB = 7;
	localparam int unsigned WORD_MSB = 15;
	localparam int unsigned NIBBLE_W = 4;
	// ************************************************************
	// Status word layout
	// ************************************************************
	localparam int unsigned FLAG_CARRY = 0;
	localparam int unsigned FLAG_PARITY = 2;
	localparam int unsigned FLAG_HALF_CARRY = 4;
	localparam int unsigned FLAG_ZERO = 6;
	localparam int unsigned FLAG_SIGN = 7;
	localparam int unsigned FLAG_STEP = 8;
	localparam int unsigned FLAG_INT_ENABLE = 9;
	localparam int unsigned FLAG_DIRECTION = 10;
	localparam int unsigned FLAG_OVERFLOW = 11;
	localparam logic [15:0] FLAGS_DEFINED_MASK = 16'h0fd5;
	localparam logic [15:0] FLAGS_RESERVED_VALUE = 16'h0000;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;
	// ************************************************************
	// Register numbering; bit 2 picks the high half in byte mode
	// ************************************************************
	localparam logic [2:0] REG_ACCUMULATOR = 3'h0;
	localparam logic [2:0] REG_COUNT = 3'h1;
	localparam logic [2:0] REG_PORT_DATA = 3'h2;
	localparam logic [2:0] REG_BASE_GENERAL = 3'h3;
	localparam logic [2:0] REG_STACK_POINTER = 3'h4;
	localparam logic [2:0] REG_FRAME_BASE = 3'h5;
	localparam logic [2:0] REG_SOURCE_INDEX = 3'h6;
	localparam logic [2:0] REG_DESTINATION_INDEX = 3'h7;
	localparam int unsigned BYTE_HIGH_SEL = 2;
	localparam logic [15:0] GPR_RESET = 16'h0000;
	localparam logic [15:0] SEG_RESET = 16'h0000;
	localparam logic [15:0] IP_RESET = 16'h0000;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	// ************************************************************
	// Types
	// ************************************************************
	typedef logic [7:0][15:0] cfs_gpr_t;
	typedef enum logic [1:0] {SEG_EXTRA, SEG_CODE, SEG_STACK, SEG_DATA} cfs_seg_e;
	typedef enum logic [1:0] {BASE_NONE, BASE_GENERAL, BASE_FRAME} cfs_base_e;
	typedef enum logic [1:0] {IDX_NONE, IDX_SOURCE, IDX_DEST} cfs_index_e;
	typedef enum logic [4:0] {
		OP_NOP, OP_MOV, OP_ADD, OP_ADC, OP_SUB, OP_SBB, OP_CMP, OP_AND, OP_OR, OP_XOR,
		OP_STC, OP_CLC, OP_CMC, OP_STD, OP_CLD, OP_STI, OP_CLI,
		OP_WR_FLAGS, OP_RD_FLAGS, OP_RD_REG, OP_WR_SEG, OP_JUMP,
		OP_MEM_ADDR, OP_PUSH, OP_POP, OP_STR_SRC, OP_STR_DST,
		OP_HALT, OP_LOCK, OP_SEG_OVR
	} cfs_op_e;

	// Segment base shifted by four plus offset; the top carry is dropped
	function automatic logic [19:0] phys_of(input logic [15:0] base, input logic [15:0] ofs);
		phys_of = {base, 4'h0} + {4'h0, ofs};
	endfunction
endpackage
`default_nettype wire

// *** rtl/cfs_agu.sv ***
// Purpose: Effective and physical address former
// Assumes: Caller selects base, index and segment values
// Notes: Purely combinational
`default_nettype none
module cfs_agu
	import cfs_pkg::*;
(
	input wire logic [15:0] base_val,
	input wire logic [15:0] index_val,
	input wire logic [15:0] disp,
	input wire logic disp8,
	input wire logic [15:0] seg_base,
	output logic [15:0] ea,
	output logic [19:0] phys
);
	logic [15:0] disp_ext;

	always_comb
	begin
		// Short displacement widened by its sign bit
		disp_ext = disp8 ? {{8{disp[BYTE_MSB]}}, disp[7:0]} : disp;
		// Sum kept at 16 bits so the offset wraps inside the segment
		ea = base_val + index_val + disp_ext;
		phys = phys_of(seg_base, ea);
	end
endmodule // cfs_agu
`default_nettype wire

// *** rtl/cfs_core.sv ***
// Purpose: Flags, register set and segmented addressing of the execution core
// Assumes: One decoded operation per cycle from the sequencer, same clock
// Notes: Interrupt requests arrive on pins and are synchronised here
`default_nettype none
module cfs_core
	import cfs_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic op_valid,
	input wire cfs_op_e op_code,
	input wire logic op_wide,
	input wire logic [2:0] op_dst,
	input wire logic [2:0] op_src,
	input wire logic op_src_imm,
	input wire logic [15:0] op_imm,
	input wire logic [3:0] op_len,
	input wire cfs_seg_e op_seg,
	input wire cfs_base_e op_base,
	input wire cfs_index_e op_index,
	input wire logic op_disp8,
	input wire logic maskable_int_req,
	input wire logic nonmaskable_int,
	output logic op_ready,
	output logic [15:0] flags_word,
	output logic [15:0] result,
	output logic result_valid,
	output logic [19:0] mem_addr,
	output cfs_seg_e mem_seg,
	output logic mem_valid,
	output logic [19:0] fetch_addr,
	output logic [15:0] ip_value,
	output logic halted,
	output logic bus_lock,
	output logic step_trap,
	output logic int_ack,
	output logic nmi_ack
);
	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		cfs_gpr_t gpr;
		logic [3:0][15:0] seg;
		logic [15:0] ip;
		logic [15:0] flags;
		logic [15:0] result;
		logic result_valid;
		logic [19:0] mem_addr;
		cfs_seg_e mem_seg;
		logic mem_valid;
		logic [19:0] fetch_addr;
		logic ready;
		logic halted;
		logic lock_armed;
		logic bus_lock;
		logic ovr_valid;
		cfs_seg_e ovr_seg;
		logic step_trap;
		logic int_ack;
		logic nmi_ack;
		logic nmi_pend;
		logic nmi_prev;
		logic [1:0] intr_sync;
		logic [1:0] nmi_sync;
	} cfs_core_s;

	cfs_core_s s, next_s;
	logic [1:0] rst_pipe;
	logic rst_n_sync;
	logic [15:0] agu_base, agu_index, agu_disp, agu_seg, agu_ea;
	logic [19:0] agu_phys;
	logic agu_disp8;
	cfs_seg_e agu_seg_sel;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [15:0] read_reg(input cfs_gpr_t g, input logic [2:0] idx,
		input logic wide);
		logic [15:0] w;
		w = g[idx[1:0]];
		if (wide)
			read_reg = g[idx];
		else if (idx[BYTE_HIGH_SEL])
			read_reg = {8'h00, w[15:8]};
		else
			read_reg = {8'h00, w[7:0]};
	endfunction

	function automatic cfs_gpr_t write_reg(input cfs_gpr_t g, input logic [2:0] idx,
		input logic wide, input logic [15:0] v);
		cfs_gpr_t r;
		r = g;
		if (wide)
			r[idx] = v;
		else if (idx[BYTE_HIGH_SEL])
			r[idx[1:0]][15:8] = v[7:0];
		else
			r[idx[1:0]][7:0] = v[7:0];
		write_reg = r;
	endfunction

	// Add or subtract with carry in; returns {carry, half carry, overflow, result}
	function automatic logic [18:0] add_sub(input logic [15:0] a, input logic [15:0] b,
		input logic cin, input logic sub, input logic wide);
		logic [16:0] sum;
		logic [4:0] nib;
		logic [15:0] bb;
		logic c, o;
		bb = sub ? ~b : b;
		sum = {1'b0, a} + {1'b0, bb} + {16'h0000, sub ^ cin};
		nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub ^ cin};
		if (wide)
		begin
			c = sum[16] ^ sub;
			o = (a[WORD_MSB] == bb[WORD_MSB]) && (sum[WORD_MSB] != a[WORD_MSB]);
		end
		else
		begin
			c = (a[8] ^ bb[8] ^ sum[8]) ^ sub;
			o = (a[BYTE_MSB] == bb[BYTE_MSB]) && (sum[BYTE_MSB] != a[BYTE_MSB]);
		end
		add_sub = {c, nib[NIBBLE_W] ^ sub, o, sum[15:0]};
	endfunction

	// Result flags written over the old word; control bits kept
	function automatic logic [15:0] set_result_flags(input logic [15:0] f,
		input logic [15:0] r, input logic c, input logic h, input logic o, input logic wide);
		logic [15:0] n;
		logic [15:0] rm;
		n = f;
		rm = wide ? r : {8'h00, r[7:0]};
		n[FLAG_CARRY] = c;
		n[FLAG_PARITY] = ~^rm[7:0];
		n[FLAG_HALF_CARRY] = h;
		n[FLAG_ZERO] = (rm == 16'h0000);
		n[FLAG_SIGN] = wide ? rm[WORD_MSB] : rm[BYTE_MSB];
		n[FLAG_OVERFLOW] = o;
		set_result_flags = n;
	endfunction

	// ************************************************************
	// Reset release
	// ************************************************************
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_n_sync = rst_pipe[1];

	// ************************************************************
	// Address operand selection
	// ************************************************************
	always_comb
	begin
		agu_base = 16'h0000;
		agu_index = 16'h0000;
		agu_disp = 16'h0000;
		agu_disp8 = 1'b0;
		agu_seg_sel = SEG_DATA;
		case (op_code)
			OP_MEM_ADDR:
			begin
				if (op_base == BASE_GENERAL)
					agu_base = s.gpr[REG_BASE_GENERAL];
				else if (op_base == BASE_FRAME)
				begin
					agu_base = s.gpr[REG_FRAME_BASE];
					agu_seg_sel = SEG_STACK;
				end
				if (op_index == IDX_SOURCE)
					agu_index = s.gpr[REG_SOURCE_INDEX];
				else if (op_index == IDX_DEST)
					agu_index = s.gpr[REG_DESTINATION_INDEX];
				agu_disp = op_imm;
				agu_disp8 = op_disp8;
				if (s.ovr_valid)
					agu_seg_sel = s.ovr_seg;
			end
			OP_PUSH:
			begin
				// Push lowers the pointer first so the word lands at the new top
				agu_base = s.gpr[REG_STACK_POINTER] - STEP_WORD;
				agu_seg_sel = SEG_STACK;
			end
			OP_POP:
			begin
				agu_base = s.gpr[REG_STACK_POINTER];
				agu_seg_sel = SEG_STACK;
			end
			OP_STR_SRC:
			begin
				agu_base = s.gpr[REG_SOURCE_INDEX];
				agu_seg_sel = s.ovr_valid ? s.ovr_seg : SEG_DATA;
			end
			OP_STR_DST:
			begin
				// Destination string side is never overridden
				agu_base = s.gpr[REG_DESTINATION_INDEX];
				agu_seg_sel = SEG_EXTRA;
			end
			default:
			begin
				agu_base = 16'h0000;
			end
		endcase
		agu_seg = s.seg[agu_seg_sel];
	end

	cfs_agu u_agu (
		.base_val(agu_base),
		.index_val(agu_index),
		.disp(agu_disp),
		.disp8(agu_disp8),
		.seg_base(agu_seg),
		.ea(agu_ea),
		.phys(agu_phys)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		logic fire, prefix, boundary, step_old;
		logic [15:0] opa, opb, str_step, f;
		logic [18:0] as;
		next_s = s;
		fire = op_valid && s.ready;
		prefix = (op_code == OP_LOCK) || (op_code == OP_SEG_OVR);
		step_old = s.flags[FLAG_STEP];
		opa = read_reg(s.gpr, op_dst, op_wide);
		opb = op_src_imm ? op_imm : read_reg(s.gpr, op_src, op_wide);
		str_step = op_wide ? STEP_WORD : STEP_BYTE;
		as = add_sub(opa, opb, 1'b0, 1'b0, op_wide);
		boundary = 1'b0;
		f = s.flags;
		next_s.intr_sync = {s.intr_sync[0], maskable_int_req};
		next_s.nmi_sync = {s.nmi_sync[0], nonmaskable_int};
		next_s.nmi_prev = s.nmi_sync[1];
		next_s.result_valid = 1'b0;
		next_s.mem_valid = 1'b0;
		next_s.step_trap = 1'b0;
		next_s.int_ack = 1'b0;
		next_s.nmi_ack = 1'b0;
		// Edge caught here so a short pulse is not lost while busy
		if (s.nmi_sync[1] && !s.nmi_prev)
			next_s.nmi_pend = 1'b1;
		if (fire)
		begin
			next_s.ip = s.ip + {12'h000, op_len};
			if (!prefix)
			begin
				next_s.ovr_valid = 1'b0;
				next_s.lock_armed = 1'b0;
				// Lock drops at the edge that takes the locked op, so idle cycles after it run unlocked
				next_s.bus_lock = 1'b0;
			end
			case (op_code)
				OP_MOV:
				begin
					next_s.gpr = write_reg(s.gpr, op_dst, op_wide, opb);
				end
				OP_ADD, OP_ADC, OP_SUB, OP_SBB, OP_CMP:
				begin
					as = add_sub(opa, opb,
						((op_code == OP_ADC) || (op_code == OP_SBB)) && s.flags[FLAG_CARRY],
						(op_code == OP_SUB) || (op_code == OP_SBB) || (op_code == OP_CMP),
						op_wide);
					next_s.flags = set_result_flags(s.flags, as[15:0], as[18], as[17], as[16],
						op_wide);
					if (op_code != OP_CMP)
						next_s.gpr = write_reg(s.gpr, op_dst, op_wide, as[15:0]);
					next_s.result = op_wide ? as[15:0] : {8'h00, as[7:0]};
					next_s.result_valid = 1'b1;
				end
				OP_AND, OP_OR, OP_XOR:
				begin
					if (op_code == OP_AND)
						opa = opa & opb;
					else if (op_code == OP_OR)
						opa = opa | opb;
					else
						opa = opa ^ opb;
					// Logic ops leave no carry, overflow or half carry
					next_s.flags = set_result_flags(s.flags, opa, 1'b0, 1'b0, 1'b0, op_wide);
					next_s.gpr = write_reg(s.gpr, op_dst, op_wide, opa);
					next_s.result = op_wide ? opa : {8'h00, opa[7:0]};
					next_s.result_valid = 1'b1;
				end
				OP_STC: next_s.flags[FLAG_CARRY] = 1'b1;
				OP_CLC: next_s.flags[FLAG_CARRY] = 1'b0;
				OP_CMC: next_s.flags[FLAG_CARRY] = ~s.flags[FLAG_CARRY];
				OP_STD: next_s.flags[FLAG_DIRECTION] = 1'b1;
				OP_CLD: next_s.flags[FLAG_DIRECTION] = 1'b0;
				OP_STI: next_s.flags[FLAG_INT_ENABLE] = 1'b1;
				OP_CLI: next_s.flags[FLAG_INT_ENABLE] = 1'b0;
				OP_WR_FLAGS:
				begin
					next_s.flags = (op_imm & FLAGS_DEFINED_MASK) | FLAGS_RESERVED_VALUE;
				end
				OP_RD_FLAGS:
				begin
					next_s.result = s.flags;
					next_s.result_valid = 1'b1;
				end
				OP_RD_REG:
				begin
					next_s.result = opa;
					next_s.result_valid = 1'b1;
				end
				OP_WR_SEG: next_s.seg[op_seg] = opb;
				OP_JUMP: next_s.ip = op_imm;
				OP_MEM_ADDR, OP_PUSH, OP_POP, OP_STR_SRC, OP_STR_DST:
				begin
					next_s.mem_addr = agu_phys;
					next_s.mem_seg = agu_seg_sel;
					next_s.mem_valid = 1'b1;
					next_s.result = agu_ea;
					if (op_code == OP_PUSH)
						next_s.gpr[REG_STACK_POINTER] = agu_base;
					else if (op_code == OP_POP)
						next_s.gpr[REG_STACK_POINTER] = s.gpr[REG_STACK_POINTER] + STEP_WORD;
					else if (op_code == OP_STR_SRC)
						next_s.gpr[REG_SOURCE_INDEX] = s.flags[FLAG_DIRECTION] ?
							agu_base - str_step : agu_base + str_step;
					else if (op_code == OP_STR_DST)
						next_s.gpr[REG_DESTINATION_INDEX] = s.flags[FLAG_DIRECTION] ?
							agu_base - str_step : agu_base + str_step;
				end
				OP_HALT:
				begin
					next_s.halted = 1'b1;
					next_s.ready = 1'b0;
				end
				OP_LOCK:
				begin
					next_s.lock_armed = 1'b1;
					next_s.bus_lock = 1'b1;
				end
				OP_SEG_OVR:
				begin
					next_s.ovr_valid = 1'b1;
					next_s.ovr_seg = op_seg;
				end
				default:
				begin
					next_s.ip = s.ip + {12'h000, op_len};
				end
			endcase
		end
		// Interrupts only between whole instructions, never inside a prefix run
		boundary = s.halted || (fire && !prefix) || (!op_valid && !s.ovr_valid && !s.lock_armed);
		f = next_s.flags;
		if (boundary)
		begin
			if (next_s.nmi_pend)
			begin
				next_s.nmi_pend = 1'b0;
				next_s.nmi_ack = 1'b1;
				f[FLAG_INT_ENABLE] = 1'b0;
				f[FLAG_STEP] = 1'b0;
				next_s.halted = 1'b0;
			end
			else if (fire && !prefix && step_old && (op_code != OP_HALT))
			begin
				next_s.step_trap = 1'b1;
				f[FLAG_STEP] = 1'b0;
			end
			else if (s.intr_sync[1] && s.flags[FLAG_INT_ENABLE])
			begin
				next_s.int_ack = 1'b1;
				f[FLAG_INT_ENABLE] = 1'b0;
				f[FLAG_STEP] = 1'b0;
				next_s.halted = 1'b0;
			end
		end
		next_s.flags = (f & FLAGS_DEFINED_MASK) | FLAGS_RESERVED_VALUE;
		next_s.ready = !next_s.halted;
		next_s.fetch_addr = phys_of(next_s.seg[SEG_CODE], next_s.ip);
	end

	always_ff @(posedge clock or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			s <= '0;
			s.gpr <= {8{GPR_RESET}};
			s.seg <= {4{SEG_RESET}};
			s.ip <= IP_RESET;
			s.flags <= FLAGS_RESET;
			s.ready <= 1'b1;
			s.mem_seg <= SEG_DATA;
			s.ovr_seg <= SEG_DATA;
		end
		else
			s <= next_s;
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign op_ready = s.ready;
	assign flags_word = s.flags;
	assign result = s.result;
	assign result_valid = s.result_valid;
	assign mem_addr = s.mem_addr;
	assign mem_seg = s.mem_seg;
	assign mem_valid = s.mem_valid;
	assign fetch_addr = s.fetch_addr;
	assign ip_value = s.ip;
	assign halted = s.halted;
	assign bus_lock = s.bus_lock;
	assign step_trap = s.step_trap;
	assign int_ack = s.int_ack;
	assign nmi_ack = s.nmi_ack;
endmodule // cfs_core
`default_nettype wire

// *** dv/cfs_core_asserts.sv ***
// Purpose: Port-level checks of the flags and addressing core
// Assumes: Sees only the ports of cfs_core
// Notes: Bound from the bench top file
`default_nettype none
module cfs_core_chk
	import cfs_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic op_valid,
	input wire cfs_op_e op_code,
	input wire logic op_wide,
	input wire logic [3:0] op_len,
	input wire logic op_ready,
	input wire logic [15:0] flags_word,
	input wire logic [15:0] result,
	input wire logic result_valid,
	input wire logic [15:0] ip_value,
	input wire logic halted,
	input wire logic bus_lock,
	input wire logic step_trap
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	sequence s_take(cfs_op_e c);
		op_valid && op_ready && op_code == c;
	endsequence
	// Zero, sign and parity checks only after ops that rewrite every arithmetic flag
	sequence s_arith;
		op_valid && op_ready && op_code inside {OP_ADD, OP_SUB} ##1 result_valid;
	endsequence
	property p_zero;
		s_arith |-> flags_word[FLAG_ZERO] == (result == 16'h0000);
	endproperty
	property p_sign;
		s_arith ##0 $past(op_wide) |-> flags_word[FLAG_SIGN] == result[15];
	endproperty
	property p_parity;
		s_arith |-> flags_word[FLAG_PARITY] == ~^result[7:0];
	endproperty
	property p_resv;
		(flags_word & ~FLAGS_DEFINED_MASK) == 16'h0000;
	endproperty
	property p_lock;
		s_take(OP_LOCK) |=> bus_lock;
	endproperty
	property p_halt;
		s_take(OP_HALT) |=> halted && !op_ready;
	endproperty
	property p_ip;
		op_valid && op_ready && op_code != OP_JUMP |=>
			ip_value == $past(ip_value) + {12'h000, $past(op_len)};
	endproperty
	property p_step;
		step_trap |-> !flags_word[FLAG_STEP];
	endproperty
	property p_dir;
		s_take(OP_STD) |=> flags_word[FLAG_DIRECTION];
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	a_sign: assert property (p_sign) else $error("sign flag wrong");
	a_parity: assert property (p_parity) else $error("parity flag wrong");
	a_resv: assert property (p_resv) else $error("reserved flag bit set");
	a_lock: assert property (p_lock) else $error("bus lock missing");
	a_halt: assert property (p_halt) else $error("halt not entered");
	a_ip: assert property (p_ip) else $error("ip not advanced");
	a_step: assert property (p_step) else $error("step flag kept");
	a_dir: assert property (p_dir) else $error("direction not set");
endmodule // cfs_core_chk
`default_nettype wire

// *** dv/test_cfs_core.sv ***
// Purpose: Directed bench for the flags and addressing core
// Assumes: Inputs change at the falling clock edge
// Notes: Each scenario judges its own results
`default_nettype none
module test_cfs_core
	import cfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, rstn = 1'b0, op_valid = 1'b0, op_wide = 1'b1, op_src_imm = 1'b1;
	logic op_disp8 = 1'b0, maskable_int_req = 1'b0, nonmaskable_int = 1'b0;
	logic [2:0] op_dst = 3'h0, op_src = 3'h0;
	logic [15:0] op_imm = 16'h0000;
	logic [3:0] op_len = 4'h2;
	cfs_op_e op_code = OP_NOP;
	cfs_seg_e op_seg = SEG_DATA;
	cfs_base_e op_base = BASE_NONE;
	cfs_index_e op_index = IDX_NONE;
	logic op_ready, result_valid, mem_valid, halted, bus_lock, step_trap, int_ack, nmi_ack;
	logic [15:0] flags_word, result, ip_value;
	logic [19:0] mem_addr, fetch_addr;
	cfs_seg_e mem_seg;
	int errors = 0, checks_done = 0;
	logic s_t, s_i, s_n;
	cfs_core i_cfs_core (.clock, .rstn, .op_valid, .op_code, .op_wide, .op_dst, .op_src,
		.op_src_imm, .op_imm, .op_len, .op_seg, .op_base, .op_index, .op_disp8,
		.maskable_int_req, .nonmaskable_int, .op_ready, .flags_word, .result, .result_valid,
		.mem_addr, .mem_seg, .mem_valid, .fetch_addr, .ip_value, .halted, .bus_lock,
		.step_trap, .int_ack, .nmi_ack);
	always #2 clock = ~clock;
	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One op per two cycles; outputs are read at the falling edge after the taking edge
	task automatic iss(input cfs_op_e c, input logic [2:0] d, input logic [15:0] v);
		@(negedge clock);
		op_code = c;
		op_dst = d;
		op_src = d;
		op_src_imm = (c != OP_RD_REG);
		op_imm = v;
		op_valid = 1'b1;
		@(negedge clock);
		op_valid = 1'b0;
	endtask
	// Pulses last one cycle, so every cycle of the window is looked at
	task automatic watch();
		s_t = 1'b0;
		s_i = 1'b0;
		s_n = 1'b0;
		repeat (8)
		begin
			@(negedge clock);
			s_t |= step_trap;
			s_i |= int_ack;
			s_n |= nmi_ack;
		end
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_arith();
		iss(OP_MOV, 3'h0, 16'h7fff);
		iss(OP_ADD, 3'h0, 16'h0001);
		chk(result, 20'h08000);
		chk(flags_word, 20'h00894);
		iss(OP_MOV, 3'h1, 16'h0000);
		iss(OP_SUB, 3'h1, 16'h0001);
		chk(result, 20'h0ffff);
		chk(flags_word, 20'h00095);
	endtask
	task automatic t_bytes();
		op_wide = 1'b0;
		iss(OP_MOV, 3'h4, 16'h0012);
		iss(OP_MOV, 3'h0, 16'h0034);
		iss(OP_ADD, 3'h0, 16'h00cc);
		chk(flags_word, 20'h00055);
		op_wide = 1'b1;
		iss(OP_RD_REG, 3'h0, 16'h0000);
		chk(result, 20'h01200);
	endtask
	task automatic t_flags();
		iss(OP_WR_FLAGS, 3'h0, 16'hfeff);
		chk(flags_word, 20'h00ed5);
		iss(OP_RD_FLAGS, 3'h0, 16'h0000);
		chk(result, 20'h00ed5);
		iss(OP_WR_FLAGS, 3'h0, 16'h0100);
		fork
			iss(OP_NOP, 3'h0, 16'h0000);
			watch();
		join
		chk(s_t, 20'h1);
		chk(flags_word[FLAG_STEP], 20'h0);
	endtask
	task automatic t_string();
		op_seg = SEG_EXTRA;
		iss(OP_WR_SEG, 3'h0, 16'h1000);
		iss(OP_MOV, 3'h7, 16'h0100);
		iss(OP_STD, 3'h0, 16'h0000);
		op_wide = 1'b0;
		iss(OP_STR_DST, 3'h0, 16'h0000);
		chk(mem_addr, 20'h10100);
		chk(mem_seg, SEG_EXTRA);
		op_wide = 1'b1;
		iss(OP_CLD, 3'h0, 16'h0000);
		iss(OP_STR_DST, 3'h0, 16'h0000);
		chk(mem_addr, 20'h100ff);
		iss(OP_RD_REG, 3'h7, 16'h0000);
		chk(result, 20'h00101);
	endtask
	task automatic t_addr();
		op_seg = SEG_STACK;
		iss(OP_WR_SEG, 3'h0, 16'h2000);
		op_seg = SEG_DATA;
		iss(OP_WR_SEG, 3'h0, 16'h3000);
		iss(OP_MOV, 3'h5, 16'hfff0);
		op_base = BASE_FRAME;
		iss(OP_MEM_ADDR, 3'h0, 16'h0020);
		chk(result, 20'h00010);
		chk(mem_addr, 20'h20010);
		op_disp8 = 1'b1;
		iss(OP_MEM_ADDR, 3'h0, 16'h00f0);
		chk(mem_addr, 20'h2ffe0);
		op_disp8 = 1'b0;
		iss(OP_SEG_OVR, 3'h0, 16'h0000);
		iss(OP_MEM_ADDR, 3'h0, 16'h0020);
		chk(mem_addr, 20'h30010);
		op_base = BASE_NONE;
		iss(OP_MEM_ADDR, 3'h0, 16'h1234);
		chk(mem_addr, 20'h31234);
		iss(OP_MOV, 3'h4, 16'h0000);
		iss(OP_PUSH, 3'h0, 16'h0000);
		chk(mem_addr, 20'h2fffe);
	endtask
	task automatic t_lock();
		iss(OP_LOCK, 3'h0, 16'h0000);
		chk(bus_lock, 20'h1);
		iss(OP_MOV, 3'h1, 16'h0005);
		chk(bus_lock, 20'h0);
	endtask
	task automatic t_halt();
		iss(OP_WR_FLAGS, 3'h0, 16'h0000);
		iss(OP_HALT, 3'h0, 16'h0000);
		chk(op_ready, 20'h0);
		maskable_int_req = 1'b1;
		watch();
		chk(s_i, 20'h0);
		chk(halted, 20'h1);
		nonmaskable_int = 1'b1;
		watch();
		nonmaskable_int = 1'b0;
		chk(s_n, 20'h1);
		chk(halted, 20'h0);
		iss(OP_STI, 3'h0, 16'h0000);
		watch();
		maskable_int_req = 1'b0;
		chk(s_i, 20'h1);
		chk(flags_word[FLAG_INT_ENABLE], 20'h0);
	endtask
	// Carry-in ops, logic ops, flag ops, jump, pop, string source and indexed modes
	task automatic t_more();
		iss(OP_STC, 3'h0, 16'h0000);
		iss(OP_CMC, 3'h0, 16'h0000);
		chk(flags_word, 20'h00000);
		iss(OP_CMC, 3'h0, 16'h0000);
		iss(OP_MOV, 3'h2, 16'h00ff);
		iss(OP_ADC, 3'h2, 16'h0001);
		chk(result_valid, 20'h1);
		chk(result, 20'h00101);
		chk(flags_word, 20'h00010);
		iss(OP_STC, 3'h0, 16'h0000);
		iss(OP_SBB, 3'h2, 16'h0001);
		chk(result, 20'h000ff);
		chk(flags_word, 20'h00014);
		iss(OP_CMP, 3'h2, 16'h00ff);
		chk(flags_word, 20'h00044);
		iss(OP_AND, 3'h2, 16'h0f0f);
		chk(result, 20'h0000f);
		iss(OP_OR, 3'h2, 16'h8000);
		chk(flags_word, 20'h00084);
		iss(OP_XOR, 3'h2, 16'h800f);
		chk(flags_word, 20'h00044);
		iss(OP_STC, 3'h0, 16'h0000);
		iss(OP_CLC, 3'h0, 16'h0000);
		chk(flags_word[FLAG_CARRY], 20'h0);
		iss(OP_STI, 3'h0, 16'h0000);
		chk(flags_word[FLAG_INT_ENABLE], 20'h1);
		iss(OP_CLI, 3'h0, 16'h0000);
		chk(flags_word[FLAG_INT_ENABLE], 20'h0);
		op_seg = SEG_CODE;
		iss(OP_WR_SEG, 3'h0, 16'h4000);
		iss(OP_JUMP, 3'h0, 16'h0123);
		chk(ip_value, 20'h00123);
		chk(fetch_addr, 20'h40123);
		iss(OP_MOV, 3'h4, 16'h0010);
		iss(OP_POP, 3'h0, 16'h0000);
		chk(mem_valid, 20'h1);
		chk(mem_addr, 20'h20010);
		iss(OP_MOV, 3'h6, 16'h0050);
		op_seg = SEG_EXTRA;
		iss(OP_SEG_OVR, 3'h0, 16'h0000);
		iss(OP_STR_SRC, 3'h0, 16'h0000);
		chk(mem_addr, 20'h10050);
		iss(OP_STR_SRC, 3'h0, 16'h0000);
		chk(mem_addr, 20'h30052);
		iss(OP_MOV, 3'h3, 16'h0100);
		op_base = BASE_GENERAL;
		op_index = IDX_SOURCE;
		iss(OP_MEM_ADDR, 3'h0, 16'h0010);
		chk(mem_addr, 20'h30164);
		op_index = IDX_DEST;
		iss(OP_MEM_ADDR, 3'h0, 16'h0010);
		chk(mem_addr, 20'h30211);
		op_base = BASE_NONE;
		op_index = IDX_NONE;
	endtask
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		repeat (4) @(negedge clock);
		rstn = 1'b1;
		repeat (3) @(negedge clock);
		chk(flags_word, 20'h00000);
		chk(ip_value, 20'h00000);
		t_arith();
		t_bytes();
		t_flags();
		t_string();
		t_addr();
		t_lock();
		t_more();
		t_halt();
		tally_and_finish();
	end
	// Whole run needs well under a thousand cycles
	initial
	begin
		#20000;
		errors++;
		tally_and_finish();
	end
endmodule // test_cfs_core
bind cfs_core cfs_core_chk i_cfs_core_chk (.clock(clock), .rstn(rstn), .op_valid(op_valid),
	.op_code(op_code), .op_wide(op_wide), .op_len(op_len), .op_ready(op_ready),
	.flags_word(flags_word), .result(result), .result_valid(result_valid),
	.ip_value(ip_value), .halted(halted), .bus_lock(bus_lock), .step_trap(step_trap));
`default_nettype wire
